/* File: src/cag_pkg.sv */
// package: constants and carrier types for core address generation
// assumes one 100 mhz clock and a classic wishbone register bus
package cag_pkg;
    // word and field layout, position p of a word sits at index 35-p
    localparam int unsigned CAG_AW        = 15;
    localparam int unsigned CAG_WW        = 36;
    localparam int unsigned CAG_BASE_LSB  = 0;
    localparam int unsigned CAG_TAG_LSB   = 15;
    localparam int unsigned CAG_TAG_W     = 3;
    localparam int unsigned CAG_FLAG_LSB  = 22;
    localparam int unsigned CAG_FLAG_W    = 2;
    localparam logic [1:0]  CAG_FLAG_IND  = 2'h3;
    // register byte offsets
    localparam logic [7:0] CAG_OFS_CMD   = 8'h00;
    localparam logic [7:0] CAG_OFS_CFG   = 8'h04;
    localparam logic [7:0] CAG_OFS_IC    = 8'h08;
    localparam logic [7:0] CAG_OFS_KEYS  = 8'h0C;
    localparam logic [7:0] CAG_OFS_XRA   = 8'h10;
    localparam logic [7:0] CAG_OFS_XRB   = 8'h14;
    localparam logic [7:0] CAG_OFS_XRC   = 8'h18;
    localparam logic [7:0] CAG_OFS_ACC   = 8'h1C;
    localparam logic [7:0] CAG_OFS_ASR   = 8'h20;
    localparam logic [7:0] CAG_OFS_MAL   = 8'h24;
    localparam logic [7:0] CAG_OFS_STAT  = 8'h28;
    localparam logic [7:0] CAG_OFS_INSLO = 8'h2C;
    localparam logic [7:0] CAG_OFS_INSHI = 8'h30;
    localparam logic [7:0] CAG_OFS_OPLO  = 8'h34;
    localparam logic [7:0] CAG_OFS_OPHI  = 8'h38;
    // command bits
    localparam int unsigned CAG_CMD_FETCH = 0;
    localparam int unsigned CAG_CMD_CHA   = 1;
    localparam int unsigned CAG_CMD_MANIC = 2;
    localparam int unsigned CAG_CMD_MANKY = 3;
    localparam int unsigned CAG_CMD_TSTEP = 4;
    localparam int unsigned CAG_CMD_XFER  = 5;
    localparam int unsigned CAG_CFG_XRCLS = 0;
    // reset values
    localparam logic [14:0] CAG_RST_ADDR = 15'h0000;
    localparam logic [35:0] CAG_RST_WORD = 36'h0_0000_0000;
    typedef enum logic [9:0] {
        CAG_IDLE = 10'h001,
        CAG_IASR = 10'h002,
        CAG_IMAL = 10'h004,
        CAG_IWT  = 10'h008,
        CAG_ILAT = 10'h010,
        CAG_EMAL = 10'h020,
        CAG_EWT  = 10'h040,
        CAG_IAL  = 10'h080,
        CAG_CWT  = 10'h100,
        CAG_LSTP = 10'h200
    } cag_state_type;
    typedef struct packed {
        logic        load;
        logic [14:0] addr;
    } cag_mem_req_type;
    typedef struct packed {
        logic        valid;
        logic [35:0] data;
    } cag_mem_rsp_type;
    typedef struct packed {
        logic        req;
        logic [14:0] addr;
    } cag_ovl_req_type;
endpackage

/* File: src/cag_core.sv */
// core address generation: counter, staging register, address latch
// assumes memory and overlapped channels share clk_i
// Operation
// - loading the address latch starts memory decoding, with a load pulse; manual and transfer commands load it with no pulse
// - processor and channel a load the latch only from staging register
// - fetch copies the counter unchanged to staging, then to the latch
// - after the fetched instruction arrives, counter steps by one
// - channel a uses accumulator address bits as an incrementing counter
// - instruction bits 21 to 35 are the base address
// - bits 18 to 20 are the tag; nonzero tag selects index register
// - indexed effective address is base minus selected index register
// - without indexing the base address passes unchanged
// - effective address goes to staging register, then to the latch
// - flag bits 12 and 13 both one read the address from core
// - address formation only in i and e cycles; l makes no reference
// - counter is 15 bits and holds the next instruction address
// - counter steps once per i cycle, or in l cycle on test
// - lowest position toggles each step, higher ones binary up count
// - a position rises only when all lower are one, clearing them
// - staging register loads from adder, counter, accumulator (channel a) or console keys
// - counter feeds staging for sequential fetch and manual use
// - adder feeds staging for operands and taken one cycle transfers
// - indirect trigger makes next cycle an indirect fetch, flags ignored
// - indirect trigger is set only in late i cycle, one level deep
`timescale 1ns/1ps
`default_nettype none
module cag_core (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire cag_pkg::cag_mem_rsp_type mem_rsp_i,
    input  wire cag_pkg::cag_ovl_req_type ovl_req_i,
    output cag_pkg::cag_mem_req_type      mem_req_o
);
    import cag_pkg::*;

    cag_state_type state_ff;
    cag_state_type nxt_state;
    logic [14:0] ic_ff;
    logic [14:0] keys_ff;
    logic [14:0] xra_ff;
    logic [14:0] xrb_ff;
    logic [14:0] xrc_ff;
    logic [14:0] acc_ff;
    logic [14:0] asr_ff;
    logic [14:0] mal_ff;
    logic        load_ff;
    logic        ind_ff;
    logic        xrcls_ff;
    logic        xfer_ff;
    logic        cha_ff;
    logic [35:0] ins_ff;
    logic [35:0] op_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        wr_en;
    logic        rd_en;
    logic [14:0] ic_next;
    logic [14:0] acc_next;
    logic [14:0] base;
    logic [2:0]  tag;
    logic [14:0] xr_sel;
    logic [14:0] eff_addr;
    logic        busy;
    logic        ind_req;
    logic        stall;
    logic        man_ic_ff;
    logic        man_ky_ff;

    // per position step: toggle when every lower position is one
    function automatic logic [14:0] bin_step(input logic [14:0] v);
        logic [15:0] carry;
        logic [14:0] r;
        carry = 16'h0001;
        r = v;
        for (int i = 0; i < 15; i++) begin
            r[i] = v[i] ^ carry[i];
            carry[i + 1] = carry[i] & v[i];
        end
        return r;
    endfunction

    // merge a 15 bit field with byte enables
    function automatic logic [14:0] wmerge(
        input logic [14:0] old_v,
        input logic [31:0] d,
        input logic [3:0]  sel
    );
        logic [14:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[14:8] = d[14:8];
        end
        return r;
    endfunction

    // wishbone strobes
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    assign rd_en = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign busy = (state_ff != CAG_IDLE);
    assign stall = ovl_req_i.req;

    assign ic_next = bin_step(ic_ff);
    assign acc_next = bin_step(acc_ff);

    // address fields of the held instruction word
    assign base = ins_ff[CAG_BASE_LSB +: CAG_AW];
    assign tag = ins_ff[CAG_TAG_LSB +: CAG_TAG_W];
    assign ind_req = (ins_ff[CAG_FLAG_LSB +: CAG_FLAG_W] == CAG_FLAG_IND);

    // tag bits pick index registers; several bits or their contents
    always_comb begin
        xr_sel = 15'h0000;
        if (!xrcls_ff) begin
            if (tag[0]) begin
                xr_sel = xr_sel | xra_ff;
            end
            if (tag[1]) begin
                xr_sel = xr_sel | xrb_ff;
            end
            if (tag[2]) begin
                xr_sel = xr_sel | xrc_ff;
            end
        end
    end

    // zero select gives the base unchanged
    assign eff_addr = base - xr_sel;

    // sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CAG_IDLE: begin
                if (wr_en && wb_adr_i == CAG_OFS_CMD && wb_sel_i[0]) begin
                    if (wb_dat_i[CAG_CMD_FETCH]) begin
                        nxt_state = CAG_IASR;
                    end else if (wb_dat_i[CAG_CMD_CHA]) begin
                        nxt_state = CAG_IASR;
                    end else if (wb_dat_i[CAG_CMD_MANIC]) begin
                        nxt_state = CAG_IASR;
                    end else if (wb_dat_i[CAG_CMD_MANKY]) begin
                        nxt_state = CAG_IASR;
                    end else if (wb_dat_i[CAG_CMD_TSTEP]) begin
                        nxt_state = CAG_LSTP;
                    end else if (wb_dat_i[CAG_CMD_XFER]) begin
                        nxt_state = CAG_ILAT;
                    end
                end
            end
            CAG_IASR: begin
                nxt_state = CAG_IMAL;
            end
            CAG_IMAL: begin
                if (!stall) begin
                    nxt_state = (man_ic_ff || man_ky_ff) ? CAG_IDLE
                              : (cha_ff ? CAG_CWT : CAG_IWT);
                end
            end
            CAG_IWT: begin
                if (mem_rsp_i.valid) begin
                    nxt_state = CAG_ILAT;
                end
            end
            CAG_ILAT: begin
                nxt_state = CAG_EMAL;
            end
            CAG_EMAL: begin
                if (!stall) begin
                    nxt_state = xfer_ff ? CAG_IDLE : CAG_EWT;
                end
            end
            CAG_EWT: begin
                if (mem_rsp_i.valid) begin
                    nxt_state = ind_ff ? CAG_IAL : CAG_IDLE;
                end
            end
            CAG_IAL: begin
                nxt_state = CAG_EMAL;
            end
            CAG_CWT: begin
                if (mem_rsp_i.valid) begin
                    nxt_state = CAG_IDLE;
                end
            end
            CAG_LSTP: begin
                nxt_state = CAG_IDLE;
            end
            default: begin
                nxt_state = CAG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= CAG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // command kind latched at start; manual and channel flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cha_ff <= 1'b0;
            xfer_ff <= 1'b0;
            man_ic_ff <= 1'b0;
            man_ky_ff <= 1'b0;
        end else if (state_ff == CAG_IDLE && nxt_state != CAG_IDLE) begin
            cha_ff <= ~wb_dat_i[CAG_CMD_FETCH] & wb_dat_i[CAG_CMD_CHA];
            xfer_ff <= (nxt_state == CAG_ILAT);
            man_ic_ff <= ~wb_dat_i[CAG_CMD_FETCH] & ~wb_dat_i[CAG_CMD_CHA]
                         & wb_dat_i[CAG_CMD_MANIC];
            man_ky_ff <= ~wb_dat_i[CAG_CMD_FETCH] & ~wb_dat_i[CAG_CMD_CHA]
                         & ~wb_dat_i[CAG_CMD_MANIC] & wb_dat_i[CAG_CMD_MANKY];
        end
    end

    // staging register source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            asr_ff <= CAG_RST_ADDR;
        end else if (state_ff == CAG_IASR) begin
            if (cha_ff) begin
                asr_ff <= acc_ff;
            end else if (man_ky_ff) begin
                asr_ff <= keys_ff;
            end else begin
                asr_ff <= ic_ff;
            end
        end else if (state_ff == CAG_ILAT || state_ff == CAG_IAL) begin
            asr_ff <= eff_addr;
        end
    end

    // address latch and decode start pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mal_ff <= CAG_RST_ADDR;
            load_ff <= 1'b0;
        end else if (ovl_req_i.req) begin
            mal_ff <= ovl_req_i.addr;
            load_ff <= 1'b1;
        end else if (state_ff == CAG_IMAL || state_ff == CAG_EMAL) begin
            mal_ff <= asr_ff;
            load_ff <= ~xfer_ff & ~man_ic_ff & ~man_ky_ff;
        end else begin
            load_ff <= 1'b0;
        end
    end

    // instruction counter: set from bus or from staging on transfer, step per i cycle or test step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ic_ff <= CAG_RST_ADDR;
        end else if (state_ff == CAG_IWT && mem_rsp_i.valid) begin
            ic_ff <= ic_next;
        end else if (state_ff == CAG_LSTP) begin
            ic_ff <= ic_next;
        end else if (state_ff == CAG_EMAL && xfer_ff && !stall) begin
            ic_ff <= asr_ff;
        end else if (wr_en && !busy && wb_adr_i == CAG_OFS_IC) begin
            ic_ff <= wmerge(ic_ff, wb_dat_i, wb_sel_i);
        end
    end

    // channel a address steps after each word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= CAG_RST_ADDR;
        end else if (state_ff == CAG_CWT && mem_rsp_i.valid) begin
            acc_ff <= acc_next;
        end else if (wr_en && !busy && wb_adr_i == CAG_OFS_ACC) begin
            acc_ff <= wmerge(acc_ff, wb_dat_i, wb_sel_i);
        end
    end

    // instruction word; in indirect fetch flags are kept from the first word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ins_ff <= CAG_RST_WORD;
        end else if (state_ff == CAG_IWT && mem_rsp_i.valid) begin
            ins_ff <= mem_rsp_i.data;
        end else if (state_ff == CAG_EWT && mem_rsp_i.valid && ind_ff) begin
            ins_ff[CAG_TAG_LSB + CAG_TAG_W - 1:0] <=
                mem_rsp_i.data[CAG_TAG_LSB + CAG_TAG_W - 1:0];
        end
    end

    // operand word captured at the end of the e cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_ff <= CAG_RST_WORD;
        end else if (state_ff == CAG_EWT && mem_rsp_i.valid && !ind_ff) begin
            op_ff <= mem_rsp_i.data;
        end else if (state_ff == CAG_CWT && mem_rsp_i.valid) begin
            op_ff <= mem_rsp_i.data;
        end
    end

    // indirect trigger set only in late i, cleared when indirect word lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_ff <= 1'b0;
        end else if (state_ff == CAG_ILAT) begin
            ind_ff <= ind_req & ~xfer_ff;
        end else if (state_ff == CAG_EWT && mem_rsp_i.valid) begin
            ind_ff <= 1'b0;
        end
    end

    // software held registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            keys_ff <= CAG_RST_ADDR;
            xra_ff <= CAG_RST_ADDR;
            xrb_ff <= CAG_RST_ADDR;
            xrc_ff <= CAG_RST_ADDR;
            xrcls_ff <= 1'b0;
        end else if (wr_en && !busy) begin
            if (wb_adr_i == CAG_OFS_KEYS) begin
                keys_ff <= wmerge(keys_ff, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == CAG_OFS_XRA) begin
                xra_ff <= wmerge(xra_ff, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == CAG_OFS_XRB) begin
                xrb_ff <= wmerge(xrb_ff, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == CAG_OFS_XRC) begin
                xrc_ff <= wmerge(xrc_ff, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == CAG_OFS_CFG && wb_sel_i[0]) begin
                xrcls_ff <= wb_dat_i[CAG_CFG_XRCLS];
            end
        end
    end

    // bus answer one cycle after request, read data registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            if (wb_adr_i == CAG_OFS_CFG) begin
                dat_ff <= {31'h0000_0000, xrcls_ff};
            end else if (wb_adr_i == CAG_OFS_IC) begin
                dat_ff <= {17'h0_0000, ic_ff};
            end else if (wb_adr_i == CAG_OFS_KEYS) begin
                dat_ff <= {17'h0_0000, keys_ff};
            end else if (wb_adr_i == CAG_OFS_XRA) begin
                dat_ff <= {17'h0_0000, xra_ff};
            end else if (wb_adr_i == CAG_OFS_XRB) begin
                dat_ff <= {17'h0_0000, xrb_ff};
            end else if (wb_adr_i == CAG_OFS_XRC) begin
                dat_ff <= {17'h0_0000, xrc_ff};
            end else if (wb_adr_i == CAG_OFS_ACC) begin
                dat_ff <= {17'h0_0000, acc_ff};
            end else if (wb_adr_i == CAG_OFS_ASR) begin
                dat_ff <= {17'h0_0000, asr_ff};
            end else if (wb_adr_i == CAG_OFS_MAL) begin
                dat_ff <= {17'h0_0000, mal_ff};
            end else if (wb_adr_i == CAG_OFS_STAT) begin
                dat_ff <= {20'h0_0000, ind_ff, 1'b0, state_ff};
            end else if (wb_adr_i == CAG_OFS_INSLO) begin
                dat_ff <= ins_ff[31:0];
            end else if (wb_adr_i == CAG_OFS_INSHI) begin
                dat_ff <= {28'h000_0000, ins_ff[35:32]};
            end else if (wb_adr_i == CAG_OFS_OPLO) begin
                dat_ff <= op_ff[31:0];
            end else if (wb_adr_i == CAG_OFS_OPHI) begin
                dat_ff <= {28'h000_0000, op_ff[35:32]};
            end else begin
                dat_ff <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign mem_req_o.load = load_ff;
    assign mem_req_o.addr = mal_ff;
endmodule
`default_nettype wire

/* File: tb/cag_core_properties.sv */
// checker: bus, latch and reset relations at the core ports
// assumes one clock domain and is bound into every cag_core
`timescale 1ns/1ps
`default_nettype none
module cag_core_properties
    import cag_pkg::*;
(
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [7:0]               wb_adr_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire cag_pkg::cag_mem_rsp_type mem_rsp_i,
    input wire cag_pkg::cag_ovl_req_type ovl_req_i,
    input wire cag_pkg::cag_mem_req_type mem_req_o
);
    logic rd;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_cause_a: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    latch_read_a: assert property (
        rd && wb_adr_i == CAG_OFS_MAL
        |=> wb_dat_o == {17'h0_0000, $past(mem_req_o.addr)})
        else $error("latch readback differs from latch");
    state_read_a: assert property (
        rd && wb_adr_i == CAG_OFS_STAT
        |=> $onehot(wb_dat_o[9:0]) && !wb_dat_o[10])
        else $error("state readback not one-hot");
    ovl_latch_a: assert property (
        ovl_req_i.req
        |=> mem_req_o.load && mem_req_o.addr == $past(ovl_req_i.addr))
        else $error("channel address not copied to latch");
    load_pulse_a: assert property (
        mem_req_o.load && !ovl_req_i.req && !$past(ovl_req_i.req)
        |=> !mem_req_o.load)
        else $error("load pulse longer than one cycle");
    reset_val_a: assert property (
        $fell(rst_i) |-> !mem_req_o.load && !wb_ack_o
        && mem_req_o.addr == CAG_RST_ADDR)
        else $error("outputs not cleared by reset");
endmodule
bind cag_core cag_core_properties chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mem_rsp_i(mem_rsp_i), .ovl_req_i(ovl_req_i), .mem_req_o(mem_req_o));
`default_nettype wire

/* File: tb/cag_mem_model.sv */
// model: core store answering the latest latch load lat_i plus one cycles after it samples the load; a new load restarts the wait
// assumes same clock as cag_core; poke_i starts a read without load
`timescale 1ns/1ps
`default_nettype none
module cag_mem_model (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire cag_pkg::cag_mem_req_type req_i,
    input  wire logic                     poke_i,
    input  wire logic [3:0]               lat_i,
    output cag_pkg::cag_mem_rsp_type      rsp_o
);
    import cag_pkg::*;
    logic [35:0] mem [0:32767];
    logic [14:0] adr_q;
    logic [3:0]  cnt;
    logic        busy;
    always @(posedge clk_i) begin
        rsp_o.valid <= 1'b0;
        rsp_o.data  <= ~rsp_o.data;
        if (rst_i) begin
            busy  <= 1'b0;
            rsp_o <= '0;
        end else if (req_i.load || poke_i) begin
            busy  <= 1'b1;
            cnt   <= lat_i;
            adr_q <= req_i.addr;
        end else if (busy && cnt == 4'h0) begin
            busy  <= 1'b0;
            rsp_o <= '{1'b1, mem[adr_q]};
        end else begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/cag_core_bench.sv */
// bench: drives cag_core over wishbone, the memory model answers loads
// assumes cag_mem_model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module cag_core_bench;
    import cag_pkg::*;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            wb_req = 1'b0;
    logic            wb_we = 1'b0;
    logic            rd_chk = 1'b0;
    logic            poke = 1'b0;
    logic            cfg = 1'b0;
    logic [7:0]      wb_adr = 8'h00;
    logic [31:0]     wb_dat = 32'h0000_0000;
    logic [3:0]      lat = 4'h0;
    logic [31:0]     q;
    logic [2:0]      tg;
    logic [14:0]     xr [3] = '{15'h0, 15'h0, 15'h0};
    logic [7:0]      ofs [5] = '{CAG_OFS_CMD, CAG_OFS_IC, CAG_OFS_ASR,
                                 CAG_OFS_MAL, 8'hFC};
    wire [31:0]      wb_dat_o;
    wire             wb_ack_o;
    cag_ovl_req_type ovl = '0;
    cag_mem_req_type mreq;
    cag_mem_rsp_type mrsp;
    int              error_cnt = 0;
    int              n_compared = 0;
    logic [31:0]     rd_q [$];
    logic [14:0]     ld_q [$];
    always #5 clk_i = ~clk_i;
    cag_core uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mem_rsp_i(mrsp), .ovl_req_i(ovl), .mem_req_o(mreq));
    cag_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq),
        .poke_i(poke), .lat_i(lat), .rsp_o(mrsp));
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic stop();
        error_cnt++;
        finish_test();
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic chk);
        int n;
        @(posedge clk_i);
        wb_req <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        rd_chk <= chk;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) stop();
        q = wb_dat_o;
        wb_req <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000, 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 1'b0);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, CAG_OFS_STAT, 32'h0000_0000, 1'b0);
            n++;
        end while (q[9:0] !== 10'h001 && n < 100);
        if (n >= 100) stop();
    endtask
    function automatic logic [14:0] xsel(input logic [2:0] t);
        xsel = 15'h0000;
        for (int i = 0; i < 3; i++)
            if (t[i] && !cfg) xsel = xsel | xr[i];
    endfunction
    task automatic fetch(input logic [14:0] ic, input logic [35:0] ins,
                         input logic [35:0] w2, input logic [35:0] op);
        logic [14:0] ea;
        ea = ins[14:0] - xsel(ins[17:15]);
        mdl.mem[ic] = ins;
        ld_q.push_back(ic);
        if (ins[23:22] == CAG_FLAG_IND) begin
            mdl.mem[ea] = w2;
            ld_q.push_back(ea);
            ea = w2[14:0] - xsel(w2[17:15]);
        end
        mdl.mem[ea] = op;
        ld_q.push_back(ea);
        wr(CAG_OFS_IC, {17'h0_0000, ic});
        wr(CAG_OFS_CMD, 32'h0000_0001);
        wr(CAG_OFS_IC, {17'h0_0000, ~ic});
        idle();
        rd(CAG_OFS_IC, {17'h0_0000, ic + 15'h0001});
        rd(CAG_OFS_ASR, {17'h0_0000, ea});
        rd(CAG_OFS_MAL, {17'h0_0000, ea});
        rd(CAG_OFS_OPLO, op[31:0]);
        rd(CAG_OFS_OPHI, {28'h000_0000, op[35:32]});
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && !wb_we && rd_chk) begin
            if (rd_q.size() == 0) stop();
            check({4'h0, wb_dat_o}, {4'h0, rd_q.pop_front()});
        end
        if (mreq.load === 1'b1)
            check({21'h00_0000, mreq.addr}, ld_q.size() ?
                  {21'h00_0000, ld_q.pop_front()} : 36'hF_0000_0000);
    end
    initial begin
        void'($urandom(62));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CAG_OFS_STAT, 32'h0000_0001);
        foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
        wr(8'hFC, 32'hFFFF_FFFF);
        wr(CAG_OFS_IC, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0000_0000);
        rd(CAG_OFS_IC, 32'h0000_7FFF);
        $display("reset and access test done");
        for (int t = 0; t < 9; t++) begin
            cfg = (t == 8);
            tg = cfg ? 3'h7 : 3'(t);
            for (int i = 0; i < 3; i++) begin
                xr[i] = 15'($urandom);
                wr(CAG_OFS_XRA + 8'(4 * i), {17'h0_0000, xr[i]});
            end
            wr(CAG_OFS_CFG, {31'h0000_0000, cfg});
            lat <= 4'($urandom % 4);
            fetch((t == 0) ? 15'h7FFF : 15'($urandom), {12'($urandom), 2'h0,
                  4'($urandom), tg, 15'($urandom)}, 36'h0_0000_0000,
                  {4'($urandom), 32'($urandom)});
        end
        $display("indexed fetch test done");
        cfg = 1'b0;
        wr(CAG_OFS_CFG, 32'h0000_0000);
        lat <= 4'h9;
        fetch(15'h0123, {12'h000, 2'h3, 4'h0, 3'h1, 15'h2000},
              {12'h000, 2'h3, 4'h0, 3'h2, 15'h0456}, 36'h9_8765_4321);
        wr(CAG_OFS_CMD, 32'h0000_0020);
        idle();
        rd(CAG_OFS_IC, {17'h0_0000, 15'h0456 - xr[1]});
        $display("indirect and transfer test done");
        wr(CAG_OFS_IC, 32'h0000_0FFF);
        wr(CAG_OFS_CMD, 32'h0000_0010);
        idle();
        rd(CAG_OFS_IC, 32'h0000_1000);
        wr(CAG_OFS_ACC, 32'h0000_7FFF);
        mdl.mem[15'h7FFF] = 36'h5_0000_00A5;
        ld_q.push_back(15'h7FFF);
        wr(CAG_OFS_CMD, 32'h0000_0002);
        idle();
        rd(CAG_OFS_ACC, 32'h0000_0000);
        rd(CAG_OFS_OPLO, 32'h0000_00A5);
        $display("step and channel test done");
        wr(CAG_OFS_KEYS, 32'h0000_5A5A);
        for (int m = 0; m < 2; m++) begin
            lat <= 4'h4;
            wr(CAG_OFS_CMD, m ? 32'h0000_0008 : 32'h0000_0004);
            poke <= 1'b1;
            @(posedge clk_i);
            poke <= 1'b0;
            idle();
            rd(CAG_OFS_ASR, m ? 32'h0000_5A5A : 32'h0000_1000);
            rd(CAG_OFS_MAL, m ? 32'h0000_5A5A : 32'h0000_1000);
        end
        $display("manual test done");
        for (int c = 0; c < 2; c++) begin
            @(posedge clk_i);
            ovl <= '{1'b1, 15'h3330 + 15'(c)};
            ld_q.push_back(15'h3330 + 15'(c));
            @(posedge clk_i);
            ovl <= '{1'b0, ~ovl.addr};
        end
        rd(CAG_OFS_MAL, 32'h0000_3331);
        @(posedge clk_i);
        check(36'(ld_q.size() + rd_q.size()), 36'h0_0000_0000);
        $display("overlapped channel test done");
        finish_test();
    end
endmodule
`default_nettype wire
